// ===== rtl/watchpoint_breakpoint_unit.sv
`timescale 1ns/100ps
// How it works
// - Watchpoints only signal events; they never stall or redirect the program.
// - A breakpoint pulses a trap request that suspends flow into exception handling.
// - Eight value/control comparator pairs; a presence output reports the unit exists.
// - Each 32-bit value resets to zero and is compared to the selected operand.
// - Control bit 0 reads 1 for an implemented pair, 0 otherwise.
// - Control bits 3-1 pick masked, eq, lt, le, gt, ge, ne; 111 reserved.
// - Control bit 4 selects unsigned (0) or signed (1) comparison.
// - Control bits 7-5 pick disabled, fetch, load, store address or data.
// - Watchpoint 0 chains match 0 with the external input by AND or OR.
// - Watchpoints 1-3 chain their match with the previous watchpoint.
// - Watchpoint 4 restarts the chain from the external input.
// - Watchpoint 5 chains match 5 with watchpoint 4.
// - Mode 2 bits 0 and 1 enable counters 0 and 1.
// - Bits 11-2 assign each watchpoint to counter 0 or counter 1.
// - Bits 21-12 choose which watchpoints raise a breakpoint; zero disables.
// - Bits 31-22 record breakpoint causes, sticky until written with zero.
// - Each counter holds a 16-bit count; reaching its match value fires a watchpoint.
// - Stop mask bits 13-0 hand matching exceptions to the development interface.
// - 32-bit registers reached only from supervisor mode or the development port.
// - Every watchpoint event is presented to the performance counters.
// - A stop records its exception type in the reason record until cleared.
module watchpoint_breakpoint_unit
  import debug_pkg::*;
#(
  parameter logic [NUM_PAIRS-1:0] PAIR_IMPLEMENTED = 8'hff  // Which pairs exist
) (
  input  wire logic                  clk,                // Core clock
  input  wire logic                  rst_n,              // Async reset, active low
  // Special-register port
  input  wire logic                  spr_valid,          // Access request
  input  wire logic                  spr_write,          // 1 write, 0 read
  input  wire logic [INDEX_WIDTH-1:0] spr_index,         // Register index
  input  wire logic [31:0]           spr_wdata,          // Write data
  input  wire logic                  spr_supervisor,     // Core in supervisor mode
  input  wire logic                  spr_dev_port,       // Access from development port
  output logic                       spr_ack,            // Access completed
  output logic                       spr_denied,         // Access refused
  output logic      [31:0]           spr_rdata,          // Read data
  output logic                       debug_unit_present, // Presence flag for unit register
  // Core pipeline
  input  wire logic                  fetch_valid,        // Fetch address valid
  input  wire logic [31:0]           fetch_addr,         // Fetch effective address
  input  wire logic                  load_valid,         // Load in flight
  input  wire logic                  store_valid,        // Store in flight
  input  wire logic [31:0]           ls_addr,            // Load/store effective address
  input  wire logic [31:0]           ls_data,            // Load/store data
  input  wire logic                  ext_watch_in,       // External watchpoint
  input  wire logic                  exc_valid,          // Exception taken this cycle
  input  wire logic [3:0]            exc_type,           // Exception number 0..13
  output logic                       breakpoint_trap,    // Trap request pulse
  output logic                       stop_request,       // Halt to development port
  output logic      [NUM_WATCH-1:0]  watch_event         // To performance counters
);

  logic [31:0]     value_reg   [NUM_PAIRS];
  logic [6:0]      control_reg [NUM_PAIRS];
  logic [19:0]     chain_reg;
  logic [31:0]     mode_reg;
  logic [31:0]     counter_reg [NUM_COUNTERS];
  logic [13:0]     stop_mask_reg;
  logic [13:0]     reason_reg;
  logic [1:0]      cnt_hit_reg;
  logic [NUM_PAIRS-1:0] match;
  logic [NUM_WATCH-1:0] wp;
  logic [NUM_WATCH-1:0] bp_hits;
  logic            access_ok;
  logic            wr_en;
  logic [31:0]     rd_mux;
  logic [13:0]     stop_hit;
  logic [1:0]      cnt_inc;
  logic [15:0]     cnt_next [NUM_COUNTERS];
  logic [9:0]      assign_f;
  logic [1:0]      cnt_enable;

  assign debug_unit_present = 1'b1;
  assign access_ok  = spr_valid & (spr_supervisor | spr_dev_port);
  assign wr_en      = access_ok & spr_write;
  assign assign_f   = mode_reg[CM_ASSIGN_LSB +: NUM_WATCH];
  assign cnt_enable = mode_reg[CM_ENABLE_LSB +: NUM_COUNTERS];

  // Comparators
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
      if (PAIR_IMPLEMENTED[gi]) begin : g_on
        watch_comparator u_cmp (
          .value       (value_reg[gi]),
          .condition   (compare_cond_t'(control_reg[gi][2:0])),
          .signed_cmp  (control_reg[gi][3]),
          .target      (compare_target_t'(control_reg[gi][6:4])),
          .fetch_valid (fetch_valid),
          .fetch_addr  (fetch_addr),
          .load_valid  (load_valid),
          .store_valid (store_valid),
          .ls_addr     (ls_addr),
          .ls_data     (ls_data),
          .match       (match[gi])
        );
      end else begin : g_off
        assign match[gi] = 1'b0;
      end
    end
  endgenerate

  function automatic logic chain(input logic [1:0] op, input logic own, input logic prev);
    case (op)
      CHAIN_ALONE: chain = own;
      CHAIN_AND:   chain = own & prev;
      CHAIN_OR:    chain = own | prev;
      default:     chain = 1'b0;
    endcase
  endfunction

  // Chain network; counter watchpoints come from registers, so no loop forms
  always_comb begin
    wp[0] = chain(chain_reg[1:0], match[0], ext_watch_in);
    for (int i = 1; i < 4; i++) begin
      wp[i] = chain(chain_reg[2*i +: 2], match[i], wp[i-1]);
    end
    wp[4] = chain(chain_reg[9:8], match[4], ext_watch_in);
    wp[5] = chain(chain_reg[11:10], match[5], wp[4]);
    wp[6] = chain(chain_reg[13:12], match[6], wp[5]);
    wp[7] = chain(chain_reg[15:14], match[7], wp[6]);
    wp[8] = chain(chain_reg[17:16], cnt_hit_reg[0], wp[7]);
    wp[9] = chain(chain_reg[19:18], cnt_hit_reg[1], wp[8]);
  end

  assign watch_event = wp;
  assign bp_hits     = wp & mode_reg[CM_BP_LSB +: NUM_WATCH];

  // Several watchpoints on one counter in a cycle count once
  always_comb begin
    cnt_inc[0] = cnt_enable[0] & |(wp & ~assign_f);
    cnt_inc[1] = cnt_enable[1] & |(wp & assign_f);
    for (int c = 0; c < NUM_COUNTERS; c++) begin
      cnt_next[c] = counter_reg[c][CNT_WIDTH-1:0] + 16'h0001;
    end
  end

  // Value and control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        value_reg[i]   <= VALUE_RESET;
        control_reg[i] <= CONTROL_RESET;
      end
    end else if (wr_en) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        if (spr_index == IDX_VALUE_BASE + 5'(i)) begin
          value_reg[i] <= spr_wdata;
        end
        if (spr_index == IDX_CONTROL_BASE + 5'(i)) begin
          control_reg[i] <= spr_wdata[CTL_TARGET_MSB:CTL_COND_LSB];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_reg <= CHAIN_RESET;
    end else if (wr_en && spr_index == IDX_CHAIN_MODE) begin
      chain_reg <= spr_wdata[CHAIN_WIDTH-1:0];
    end
  end

  // Mode register: cause status set by hardware wins over a clearing write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_RESET;
    end else begin
      if (wr_en && spr_index == IDX_COUNTER_MODE) begin
        mode_reg[CM_STATUS_LSB-1:0] <= spr_wdata[CM_STATUS_LSB-1:0];
        mode_reg[31:CM_STATUS_LSB]  <= (mode_reg[31:CM_STATUS_LSB] & spr_wdata[31:CM_STATUS_LSB])
                                       | bp_hits;
      end else begin
        mode_reg[31:CM_STATUS_LSB] <= mode_reg[31:CM_STATUS_LSB] | bp_hits;
      end
    end
  end

  // Counters; a software write overrides the increment of the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NUM_COUNTERS; c++) begin
        counter_reg[c] <= COUNTER_RESET;
      end
      cnt_hit_reg <= 2'b00;
    end else begin
      for (int c = 0; c < NUM_COUNTERS; c++) begin
        cnt_hit_reg[c] <= 1'b0;
        if (wr_en && spr_index == IDX_COUNTER_BASE + 5'(c)) begin
          counter_reg[c] <= spr_wdata;
        end else if (cnt_inc[c]) begin
          counter_reg[c][CNT_WIDTH-1:0] <= cnt_next[c];
          cnt_hit_reg[c] <= (cnt_next[c] == counter_reg[c][31:CNT_MATCH_LSB]);
        end
      end
    end
  end

  // Breakpoint trap pulse, one cycle after the enabled watchpoint
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      breakpoint_trap <= 1'b0;
    end else begin
      breakpoint_trap <= |bp_hits;
    end
  end

  // Stop mask and stop request
  always_comb begin
    stop_hit = '0;
    if (exc_valid && exc_type < 4'(STOP_WIDTH)) begin
      stop_hit[exc_type] = stop_mask_reg[exc_type];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_mask_reg <= STOP_RESET;
      stop_request  <= 1'b0;
    end else begin
      if (wr_en && spr_index == IDX_STOP_MASK) begin
        stop_mask_reg <= spr_wdata[STOP_WIDTH-1:0];
      end
      stop_request <= |stop_hit;
    end
  end

  // Reason record: a new stop wins over a clearing write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reason_reg <= STOP_RESET;
    end else if (wr_en && spr_index == IDX_STOP_REASON) begin
      reason_reg <= spr_wdata[STOP_WIDTH-1:0] | stop_hit;
    end else begin
      reason_reg <= reason_reg | stop_hit;
    end
  end

  // Read mux; reserved bits and unknown indices read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (spr_index == IDX_VALUE_BASE + 5'(i)) begin
        rd_mux = value_reg[i];
      end
      if (spr_index == IDX_CONTROL_BASE + 5'(i)) begin
        rd_mux = {24'h00_0000, control_reg[i], PAIR_IMPLEMENTED[i]};
      end
    end
    for (int c = 0; c < NUM_COUNTERS; c++) begin
      if (spr_index == IDX_COUNTER_BASE + 5'(c)) begin
        rd_mux = counter_reg[c];
      end
    end
    case (spr_index)
      IDX_CHAIN_MODE:   rd_mux = {12'h000, chain_reg};
      IDX_COUNTER_MODE: rd_mux = mode_reg;
      IDX_STOP_MASK:    rd_mux = {18'h0_0000, stop_mask_reg};
      IDX_STOP_REASON:  rd_mux = {18'h0_0000, reason_reg};
      default:          rd_mux = rd_mux;
    endcase
  end

  // Answer one cycle after the request; refused reads return zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spr_ack    <= 1'b0;
      spr_denied <= 1'b0;
      spr_rdata  <= 32'h0000_0000;
    end else begin
      spr_ack    <= spr_valid;
      spr_denied <= spr_valid & ~access_ok;
      if (access_ok && !spr_write) begin
        spr_rdata <= rd_mux;
      end else if (spr_valid) begin
        spr_rdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// ===== rtl/debug_pkg.sv
package debug_pkg;

  localparam int NUM_PAIRS    = 8;
  localparam int NUM_WATCH    = 10;
  localparam int NUM_COUNTERS = 2;
  localparam int STOP_WIDTH   = 14;
  localparam int INDEX_WIDTH  = 5;

  // Special-register indices inside the debug group
  localparam logic [4:0] IDX_VALUE_BASE   = 5'h00;
  localparam logic [4:0] IDX_CONTROL_BASE = 5'h08;
  localparam logic [4:0] IDX_CHAIN_MODE   = 5'h10;
  localparam logic [4:0] IDX_COUNTER_MODE = 5'h11;
  localparam logic [4:0] IDX_COUNTER_BASE = 5'h12;
  localparam logic [4:0] IDX_STOP_MASK    = 5'h14;
  localparam logic [4:0] IDX_STOP_REASON  = 5'h15;

  // Compare control fields
  localparam int CTL_PRESENT_BIT = 0;
  localparam int CTL_COND_LSB    = 1;
  localparam int CTL_SIGNED_BIT  = 4;
  localparam int CTL_TARGET_LSB  = 5;
  localparam int CTL_TARGET_MSB  = 7;

  // Chain mode: two bits per watchpoint, 20 bits used
  localparam int CHAIN_WIDTH = 20;

  // Breakpoint/counter mode fields
  localparam int CM_ENABLE_LSB = 0;
  localparam int CM_ASSIGN_LSB = 2;
  localparam int CM_BP_LSB     = 12;
  localparam int CM_STATUS_LSB = 22;

  // Watch event counter fields
  localparam int CNT_WIDTH     = 16;
  localparam int CNT_MATCH_LSB = 16;

  localparam logic [31:0] VALUE_RESET   = 32'h0000_0000;
  localparam logic [6:0]  CONTROL_RESET = 7'h00;
  localparam logic [19:0] CHAIN_RESET   = 20'h0_0000;
  localparam logic [31:0] MODE_RESET    = 32'h0000_0000;
  localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
  localparam logic [13:0] STOP_RESET    = 14'h0000;

  typedef enum logic [2:0] {
    COND_MASKED   = 3'h0,
    COND_EQUAL    = 3'h1,
    COND_LESS     = 3'h2,
    COND_LESS_EQ  = 3'h3,
    COND_GREATER  = 3'h4,
    COND_GREAT_EQ = 3'h5,
    COND_NOT_EQ   = 3'h6,
    COND_RESERVED = 3'h7
  } compare_cond_t;

  typedef enum logic [2:0] {
    TGT_DISABLED   = 3'h0,
    TGT_FETCH_ADDR = 3'h1,
    TGT_LOAD_ADDR  = 3'h2,
    TGT_STORE_ADDR = 3'h3,
    TGT_LOAD_DATA  = 3'h4,
    TGT_STORE_DATA = 3'h5,
    TGT_LS_ADDR    = 3'h6,
    TGT_LS_DATA    = 3'h7
  } compare_target_t;

  typedef enum logic [1:0] {
    CHAIN_ALONE    = 2'h0,
    CHAIN_AND      = 2'h1,
    CHAIN_OR       = 2'h2,
    CHAIN_RESERVED = 2'h3
  } chain_op_t;

endpackage

// ===== rtl/watch_comparator.sv
`timescale 1ns/100ps
module watch_comparator
  import debug_pkg::*;
(
  input  wire logic            [31:0] value,        // Programmed watch value
  input  wire compare_cond_t          condition,    // Compare condition
  input  wire logic                   signed_cmp,   // Signed arithmetic
  input  wire compare_target_t        target,       // Operand select
  input  wire logic                   fetch_valid,  // Fetch address valid
  input  wire logic            [31:0] fetch_addr,   // Fetch effective address
  input  wire logic                   load_valid,   // Load in flight
  input  wire logic                   store_valid,  // Store in flight
  input  wire logic            [31:0] ls_addr,      // Load/store effective address
  input  wire logic            [31:0] ls_data,      // Load/store data
  output logic                        match         // Comparison holds
);

  logic [31:0] operand;
  logic        live;
  logic        eq;
  logic        lt;

  always_comb begin
    operand = ls_addr;
    live    = 1'b0;
    case (target)
      TGT_FETCH_ADDR: begin
        operand = fetch_addr;
        live    = fetch_valid;
      end
      TGT_LOAD_ADDR:  live = load_valid;
      TGT_STORE_ADDR: live = store_valid;
      TGT_LS_ADDR:    live = load_valid | store_valid;
      TGT_LOAD_DATA: begin
        operand = ls_data;
        live    = load_valid;
      end
      TGT_STORE_DATA: begin
        operand = ls_data;
        live    = store_valid;
      end
      TGT_LS_DATA: begin
        operand = ls_data;
        live    = load_valid | store_valid;
      end
      default: live = 1'b0;
    endcase
  end

  // Operand is on the left: "less than" means operand < value
  assign eq = (operand == value);
  assign lt = signed_cmp ? ($signed(operand) < $signed(value)) : (operand < value);

  always_comb begin
    case (condition)
      COND_EQUAL:    match = live & eq;
      COND_LESS:     match = live & lt;
      COND_LESS_EQ:  match = live & (lt | eq);
      COND_GREATER:  match = live & ~lt & ~eq;
      COND_GREAT_EQ: match = live & ~lt;
      COND_NOT_EQ:   match = live & ~eq;
      default:       match = 1'b0;
    endcase
  end

endmodule

// ===== bench/watch_unit_monitor.sv
`timescale 1ns/100ps
module watch_unit_monitor (
  input wire logic        clk,                // Clock
  input wire logic        rst_n,              // Reset
  input wire logic        spr_valid,          // Request
  input wire logic        spr_supervisor,     // Supervisor
  input wire logic        spr_dev_port,       // Dev port
  input wire logic        spr_ack,            // Ack
  input wire logic        spr_denied,         // Refused
  input wire logic [31:0] spr_rdata,          // Read data
  input wire logic        debug_unit_present, // Present
  input wire logic [9:0]  watch_event,        // Events
  input wire logic        exc_valid,          // Exception
  input wire logic [3:0]  exc_type,           // Exception number
  input wire logic        breakpoint_trap,    // Trap
  input wire logic        stop_request        // Halt
);
  logic any_watch;
  assign any_watch = |watch_event;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ack_follows_a: assert property (spr_valid |=> spr_ack)
    else $error("request without ack");
  ack_cause_a: assert property (spr_ack |-> $past(spr_valid))
    else $error("ack without request");
  denied_access_a: assert property (spr_valid && !spr_supervisor && !spr_dev_port
    |=> spr_denied && spr_rdata == 32'h0000_0000) else $error("refusal missing");
  granted_access_a: assert property (spr_valid && (spr_supervisor || spr_dev_port)
    |=> !spr_denied) else $error("legal access refused");
  unit_present_a: assert property (debug_unit_present)
    else $error("unit not present");
  trap_cause_a: assert property (breakpoint_trap |-> $past(any_watch))
    else $error("trap without watchpoint");
  stop_cause_a: assert property (stop_request |-> $past(exc_valid))
    else $error("stop without exception");
  stop_range_a: assert property (exc_valid && exc_type > 4'hd |=> !stop_request)
    else $error("stop on unknown exception");
  cover property (breakpoint_trap);
  cover property (stop_request);
  cover property (spr_denied);
endmodule
bind watchpoint_breakpoint_unit watch_unit_monitor mon_u (
  .clk(clk), .rst_n(rst_n), .spr_valid(spr_valid), .spr_supervisor(spr_supervisor),
  .spr_dev_port(spr_dev_port), .spr_ack(spr_ack), .spr_denied(spr_denied),
  .spr_rdata(spr_rdata), .debug_unit_present(debug_unit_present),
  .watch_event(watch_event), .exc_valid(exc_valid), .exc_type(exc_type),
  .breakpoint_trap(breakpoint_trap), .stop_request(stop_request));

// ===== bench/core_model.sv
`timescale 1ns/100ps
module core_model (
  input  wire logic        clk,          // Clock
  output logic             fetch_valid,  // Fetch valid
  output logic      [31:0] fetch_addr,   // Fetch address
  output logic             load_valid,   // Load
  output logic             store_valid,  // Store
  output logic      [31:0] ls_addr,      // Access address
  output logic      [31:0] ls_data,      // Access data
  output logic             ext_watch_in, // External watch
  output logic             exc_valid,    // Exception
  output logic      [3:0]  exc_type      // Exception number
);
  initial begin
    idle();
    exc_valid = 1'b0;
    exc_type = 4'h0;
  end
  task put(input int k, input logic [31:0] a, d, input logic e);
    fetch_valid = (k == 1);
    load_valid = (k == 2);
    store_valid = (k == 3);
    fetch_addr = a;
    ls_addr = a;
    ls_data = d;
    ext_watch_in = e;
  endtask
  // Released operands are inverted so a stale value cannot match by luck
  task idle();
    fetch_valid = 1'b0;
    load_valid = 1'b0;
    store_valid = 1'b0;
    fetch_addr = ~fetch_addr;
    ls_addr = ~ls_addr;
    ls_data = ~ls_data;
    ext_watch_in = 1'b0;
  endtask
  task exc(input logic [3:0] t);
    @(posedge clk);
    #1 exc_valid = 1'b1;
    exc_type = t;
    @(posedge clk);
    #1 exc_valid = 1'b0;
    exc_type = ~t;
  endtask
endmodule

// ===== bench/watchpoint_breakpoint_unit_tb.sv
`timescale 1ns/100ps
module watchpoint_breakpoint_unit_tb;
  logic        clk, rst_n, spr_valid, spr_write, spr_supervisor, spr_dev_port;
  logic        spr_ack, spr_denied, debug_unit_present, ext_watch_in;
  logic        fetch_valid, load_valid, store_valid, exc_valid;
  logic        breakpoint_trap, stop_request;
  logic [4:0]  spr_index;
  logic [3:0]  exc_type;
  logic [31:0] spr_wdata, spr_rdata, fetch_addr, ls_addr, ls_data, op;
  logic [9:0]  watch_event, ev;
  logic        w;
  int          bad_count, n_tests, traps;
  watchpoint_breakpoint_unit dut_u (.clk, .rst_n, .spr_valid, .spr_write, .spr_index,
    .spr_wdata, .spr_supervisor, .spr_dev_port, .spr_ack, .spr_denied, .spr_rdata,
    .debug_unit_present, .fetch_valid, .fetch_addr, .load_valid, .store_valid, .ls_addr,
    .ls_data, .ext_watch_in, .exc_valid, .exc_type, .breakpoint_trap, .stop_request,
    .watch_event);
  core_model core_u (.clk, .fetch_valid, .fetch_addr, .load_valid, .store_valid,
    .ls_addr, .ls_data, .ext_watch_in, .exc_valid, .exc_type);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) if (breakpoint_trap === 1'b1) traps++;
  task chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task acc(input logic wr, input logic [4:0] idx, input logic [31:0] d);
    @(posedge clk);
    #1 spr_valid = 1'b1;
    spr_write = wr;
    spr_index = idx;
    spr_wdata = d;
    @(posedge clk);
    #1 spr_valid = 1'b0;
    spr_wdata = ~d;
  endtask
  task rd(input logic [4:0] idx, input logic [31:0] exp);
    acc(1'b0, idx, 32'h0000_0000);
    chk(spr_rdata, exp);
  endtask
  // One cycle of pipeline traffic; events are combinational within it
  task probe(input int k, input logic [31:0] a, d, input logic e);
    @(posedge clk);
    #1 core_u.put(k, a, d, e);
    #1 ev = watch_event;
    @(posedge clk);
    #1 core_u.idle();
  endtask
  function automatic logic cond_hit(int c, logic s, logic [31:0] o, v);
    logic lt;
    lt = s ? ($signed(o) < $signed(v)) : (o < v);
    case (c)
      1: return o == v;
      2: return lt;
      3: return lt || o == v;
      4: return !lt && o != v;
      5: return !lt;
      6: return o != v;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic tgt_hit(int t, int k, int f);
    case (t)
      1: return k == 1 && f == 0;
      2: return k == 2 && f == 0;
      3: return k == 3 && f == 0;
      4: return k == 2 && f == 1;
      5: return k == 3 && f == 1;
      6: return k > 1 && f == 0;
      7: return k > 1 && f == 1;
      default: return 1'b0;
    endcase
  endfunction
  task results();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    bad_count++;
    results();
  end
  initial begin
    {rst_n, spr_valid, spr_write, spr_index, spr_wdata, spr_dev_port} = '0;
    spr_supervisor = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 32; i++) begin
      rd(i[4:0], (i >= 8 && i < 16) ? 32'h0000_0001 : 32'h0000_0000);
    end
    $display("test reset values done");
    acc(1'b1, 5'h00, 32'hA5A5_5A5A);
    rd(5'h00, 32'hA5A5_5A5A);
    acc(1'b1, 5'h08, 32'h0000_00fe);
    rd(5'h08, 32'h0000_00ff);
    spr_supervisor = 1'b0;
    acc(1'b1, 5'h01, 32'h1234_5678);
    chk(32'(spr_denied), 32'h0000_0001);
    spr_dev_port = 1'b1;
    acc(1'b1, 5'h02, 32'h0000_0077);
    rd(5'h02, 32'h0000_0077);
    spr_dev_port = 1'b0;
    spr_supervisor = 1'b1;
    rd(5'h01, 32'h0000_0000);
    $display("test access done");
    // Last operand is below the value when signed, above it when unsigned
    acc(1'b1, 5'h00, 32'h0000_0010);
    for (int c = 0; c < 8; c++) for (int s = 0; s < 2; s++) begin
      acc(1'b1, 5'h08, {24'h0000_00, 3'h2, s[0], c[2:0], 1'b0});
      for (int n = 0; n < 4; n++) begin
        op = (n == 3) ? 32'hFFFF_FFF0 : 32'h0000_000f + n;
        probe(2, op, ~op, 1'b0);
        chk(32'(ev[0]), 32'(cond_hit(c, s[0], op, 32'h0000_0010)));
      end
    end
    $display("test conditions done");
    acc(1'b1, 5'h00, 32'h0000_0040);
    for (int t = 0; t < 8; t++) begin
      acc(1'b1, 5'h08, {24'h0000_00, t[2:0], 1'b0, 3'h1, 1'b0});
      for (int k = 1; k < 4; k++) for (int f = 0; f < 2; f++) begin
        probe(k, f ? 32'hFFFF_FFBF : 32'h0000_0040, f ? 32'h0000_0040 : 32'hFFFF_FFBF, 1'b0);
        chk(32'(ev[0]), 32'(tgt_hit(t, k, f)));
      end
    end
    $display("test targets done");
    for (int p = 0; p < 8; p++) begin
      acc(1'b1, p[4:0], (p == 1) ? 32'h0000_0041 : 32'h0000_0040);
      acc(1'b1, 5'h08 + p[4:0], 32'h0000_0042);
    end
    for (int c = 0; c < 4; c++) for (int e = 0; e < 2; e++) begin
      acc(1'b1, 5'h10, 32'h0000_1408 | c | (c << 8));
      probe(2, 32'h0000_0040, 32'h0000_0000, e[0]);
      w = (c == 0 || c == 2) ? 1'b1 : (c == 1) ? e[0] : 1'b0;
      chk(32'(ev[7:0]), 32'({1'b1, w, w, w, 2'b11, w, w}));
    end
    chk(traps, 32'h0000_0000);
    $display("test chaining done");
    acc(1'b1, 5'h10, 32'h0000_0000);
    acc(1'b1, 5'h12, 32'h0003_0000);
    acc(1'b1, 5'h11, 32'h0000_0006);
    probe(2, 32'h0000_0040, 32'h0000_0000, 1'b0);
    rd(5'h13, 32'h0000_0001);
    rd(5'h12, 32'h0003_0000);
    acc(1'b1, 5'h11, 32'h0010_0001);
    repeat (3) probe(2, 32'h0000_0040, 32'h0000_0000, 1'b0);
    repeat (4) @(posedge clk);
    chk(traps, 32'h0000_0001);
    // The counter watchpoint is assigned to counter 0 as well, so it counts itself once
    rd(5'h12, 32'h0003_0004);
    rd(5'h11, 32'h4010_0001);
    acc(1'b1, 5'h11, 32'h0010_0001);
    rd(5'h11, 32'h0010_0001);
    $display("test counters done");
    acc(1'b1, 5'h14, 32'h0000_2001);
    for (int t = 0; t < 16; t++) begin
      core_u.exc(t[3:0]);
      chk(32'(stop_request), 32'(t == 0 || t == 13));
    end
    rd(5'h15, 32'h0000_2001);
    acc(1'b1, 5'h15, 32'h0000_0000);
    rd(5'h15, 32'h0000_0000);
    $display("test stop done");
    results();
  end
endmodule
